// ---- logic/pif_pkg.sv ----
// Constants for the peripheral interrupt flag, enable and priority bank.
// Assumes an 8-bit register port on the core clock and a synchronous reset.
// Summary of operation
// - Serial port two done flag, bit 7, sets on transfer end, software clears.
// - Bus collision two flag, bit 6, sets on collision, cleared only by software.
// - Receiver two flag, bit 5, read-only, set while data waits, cleared by reading.
// - Transmitter two flag, bit 4, read-only, set when empty, cleared by writing.
// - Timer four match flag, bit 3, sets on period match, software clears.
// - Capture mode: unit flags, bits 2 to 0, set on timer capture.
// - Compare mode: unit flags set on compare match, stay until software clears.
// - Pulse-width mode: nothing sets that unit's flag.
// - Single-level mode needs the global peripheral enable; without it, no request.
// - First enable register bits pass or block matching first-bank sources.
// - Second enable register bits 5, 4 and 2 unimplemented, read zero.
// - Third enable register bits match the third flag register positions.
// - Priority bits steer requests only while priority levels are enabled.
// - Flags set regardless of their own enable or the global enable.
// - Priority levels enable bit: 1 gives two levels, 0 single-level mode.
package pif_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;

  // Register offsets on the register port.
  localparam logic [3:0] OFF_FLAGS3 = 4'h0;
  localparam logic [3:0] OFF_EN1 = 4'h1;
  localparam logic [3:0] OFF_EN2 = 4'h2;
  localparam logic [3:0] OFF_EN3 = 4'h3;
  localparam logic [3:0] OFF_PRI1 = 4'h4;
  localparam logic [3:0] OFF_CTRL = 4'h5;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0] OFF_IRQ_CLR = 4'h7;
  localparam logic [3:0] OFF_IRQ_EN = 4'h8;

  // Bit positions in the third flag register and third enable register.
  localparam int BIT_SSP2 = 7;
  localparam int BIT_BCL2 = 6;
  localparam int BIT_RX2 = 5;
  localparam int BIT_TX2 = 4;
  localparam int BIT_TMR4 = 3;
  localparam int BIT_CC5 = 2;
  localparam int BIT_CC3 = 0;

  // Control register bit positions.
  localparam int BIT_PRIO_EN = 7;
  localparam int BIT_GLOBAL_EN = 6;

  // Interrupt status bit positions.
  localparam int BIT_EV_HI = 0;
  localparam int BIT_EV_LO = 1;

  // Writable masks and reset values.
  localparam logic [7:0] FLAGS3_SW_MASK = 8'hcf;
  localparam logic [7:0] EN2_MASK = 8'hcb;
  localparam logic [7:0] CTRL_MASK = 8'hc0;
  localparam logic [7:0] IRQ_MASK = 8'h03;
  localparam logic [7:0] FLAGS3_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] PRI1_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Operating mode of each capture/compare unit.
  typedef enum logic [1:0] {
    PIF_CC_OFF = 2'b00,
    PIF_CC_CAPTURE = 2'b01,
    PIF_CC_COMPARE = 2'b10,
    PIF_CC_PWM = 2'b11
  } pif_ccmode_e;

endpackage : pif_pkg

// ---- logic/pif_req_router.sv ----
// Combines one bank of flags, enables and priorities into request terms.
// Assumes all inputs are registered values on the core clock.
`timescale 1ns/100ps
module pif_req_router #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] flags_i,
  input wire logic [WIDTH-1:0] enables_i,
  input wire logic [WIDTH-1:0] prios_i,
  output logic hi_o,
  output logic lo_o,
  output logic any_o
);
  logic [WIDTH-1:0] pending;

  // Refuse a bank width the logic cannot serve.
  if (WIDTH < 1) begin : g_chk
    $error("pif_req_router: WIDTH must be at least one");
  end

  // A source is pending only with both its flag and enable set.
  assign pending = flags_i & enables_i;
  assign hi_o = |(pending & prios_i);
  assign lo_o = |(pending & ~prios_i);
  assign any_o = |pending;
endmodule : pif_req_router

// ---- logic/pif_bank_top.sv ----
// Peripheral interrupt flag, enable and priority bank with its register port.
// Assumes event inputs come from peripherals on the same clock, one-cycle pulses,
// and that the first and second flag banks are kept elsewhere and fed in here.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
module pif_bank_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [pif_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pif_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pif_pkg::DATA_W-1:0] RDATA_O,
  input wire logic SSP2_DONE_I,
  input wire logic BCL2_DETECT_I,
  input wire logic RX2_LOAD_I,
  input wire logic RX2_BUF_READ_I,
  input wire logic TX2_EMPTIED_I,
  input wire logic TX2_BUF_WRITE_I,
  input wire logic TMR4_MATCH_I,
  input wire logic [2:0] CC_CAPTURE_I,
  input wire logic [2:0] CC_MATCH_I,
  input wire logic [5:0] CC_MODE_I,
  input wire logic [7:0] FLAGS1_I,
  input wire logic [7:0] FLAGS2_I,
  input wire logic [7:0] PRIO2_I,
  input wire logic [7:0] PRIO3_I,
  output logic [7:0] FLAGS3_O,
  output logic HI_REQ_O,
  output logic LO_REQ_O,
  output logic IRQ_O
);
  import pif_pkg::*;

  logic [7:0] flags3_q;
  logic [7:0] flags3_d;
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic [7:0] en3_q;
  logic [7:0] pri1_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_en_q;
  logic [7:0] rdata_d;
  logic [7:0] hw_set;
  logic [2:0] cc_set;
  logic hi_d;
  logic lo_d;
  logic prio_en;
  logic global_en;
  logic hi1;
  logic lo1;
  logic any1;
  logic hi2;
  logic lo2;
  logic any2;
  logic hi3;
  logic lo3;
  logic any3;
  logic hi_rise;
  logic lo_rise;
  logic [7:0] rise_set;

  // True when a strobe addresses the given register.
  function automatic logic hit(input logic stb, input logic [3:0] a, input logic [3:0] off);
    hit = stb && (a == off);
  endfunction : hit

  assign prio_en = ctrl_q[BIT_PRIO_EN];
  assign global_en = ctrl_q[BIT_GLOBAL_EN];

  // Capture events count only in capture mode, matches only in compare mode.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cc_set[i] = (CC_CAPTURE_I[i] && (CC_MODE_I[2*i +: 2] == PIF_CC_CAPTURE))
        || (CC_MATCH_I[i] && (CC_MODE_I[2*i +: 2] == PIF_CC_COMPARE));
    end
  end

  // Hardware set terms, independent of any enable bit.
  always_comb begin
    hw_set = 8'h00;
    hw_set[BIT_SSP2] = SSP2_DONE_I;
    hw_set[BIT_BCL2] = BCL2_DETECT_I;
    hw_set[BIT_RX2] = RX2_LOAD_I;
    hw_set[BIT_TX2] = TX2_EMPTIED_I;
    hw_set[BIT_TMR4] = TMR4_MATCH_I;
    hw_set[BIT_CC5:BIT_CC3] = cc_set;
  end

  // Next flag value: software writes the writable bits, buffer accesses clear
  // the two read-only bits, and a hardware set always beats a clear.
  always_comb begin
    flags3_d = flags3_q;
    if (hit(WR_I, ADDR_I, OFF_FLAGS3)) begin
      flags3_d = (flags3_q & ~FLAGS3_SW_MASK) | (WDATA_I & FLAGS3_SW_MASK);
    end
    if (RX2_BUF_READ_I) begin
      flags3_d[BIT_RX2] = 1'b0;
    end
    if (TX2_BUF_WRITE_I) begin
      flags3_d[BIT_TX2] = 1'b0;
    end
    flags3_d = flags3_d | hw_set;
  end

  // Third flag register.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      flags3_q <= FLAGS3_RST;
    end else begin
      flags3_q <= flags3_d;
    end
  end

  // Enable registers; the second has only five implemented bits.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en1_q <= EN_RST;
      en2_q <= EN_RST;
      en3_q <= EN_RST;
    end else begin
      if (hit(WR_I, ADDR_I, OFF_EN1)) begin
        en1_q <= WDATA_I;
      end
      if (hit(WR_I, ADDR_I, OFF_EN2)) begin
        en2_q <= WDATA_I & EN2_MASK;
      end
      if (hit(WR_I, ADDR_I, OFF_EN3)) begin
        en3_q <= WDATA_I;
      end
    end
  end

  // First priority register, all high priority after reset.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pri1_q <= PRI1_RST;
    end else if (hit(WR_I, ADDR_I, OFF_PRI1)) begin
      pri1_q <= WDATA_I;
    end
  end

  // Control register holding the priority levels and global peripheral enables.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_q <= CTRL_RST;
    end else if (hit(WR_I, ADDR_I, OFF_CTRL)) begin
      ctrl_q <= WDATA_I & CTRL_MASK;
    end
  end

  // One router per bank.
  pif_req_router #(.WIDTH(8)) u_bank1 (
    .flags_i(FLAGS1_I),
    .enables_i(en1_q),
    .prios_i(pri1_q),
    .hi_o(hi1),
    .lo_o(lo1),
    .any_o(any1)
  );

  pif_req_router #(.WIDTH(8)) u_bank2 (
    .flags_i(FLAGS2_I),
    .enables_i(en2_q),
    .prios_i(PRIO2_I),
    .hi_o(hi2),
    .lo_o(lo2),
    .any_o(any2)
  );

  pif_req_router #(.WIDTH(8)) u_bank3 (
    .flags_i(flags3_q),
    .enables_i(en3_q),
    .prios_i(PRIO3_I),
    .hi_o(hi3),
    .lo_o(lo3),
    .any_o(any3)
  );

  // With priority levels, the priority bits pick the line; without them every
  // source goes to the high line and only while the global enable is set.
  always_comb begin
    if (prio_en) begin
      hi_d = hi1 | hi2 | hi3;
      lo_d = lo1 | lo2 | lo3;
    end else begin
      hi_d = global_en & (any1 | any2 | any3);
      lo_d = 1'b0;
    end
  end

  // Registered request outputs.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HI_REQ_O <= 1'b0;
      LO_REQ_O <= 1'b0;
    end else begin
      HI_REQ_O <= hi_d;
      LO_REQ_O <= lo_d;
    end
  end

  assign hi_rise = hi_d & ~HI_REQ_O;
  assign lo_rise = lo_d & ~LO_REQ_O;

  // Status set terms, placed at the named status bit positions.
  always_comb begin
    rise_set = 8'h00;
    rise_set[BIT_EV_HI] = hi_rise;
    rise_set[BIT_EV_LO] = lo_rise;
  end

  // Sticky request-rise status; a new rise beats a clear in the same cycle.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_stat_q <= 8'h00;
    end else begin
      irq_stat_q <= ((hit(WR_I, ADDR_I, OFF_IRQ_CLR) ? irq_stat_q & ~WDATA_I : irq_stat_q)
        | rise_set) & IRQ_MASK;
    end
  end

  // Interrupt enable register for the status bits.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_en_q <= 8'h00;
    end else if (hit(WR_I, ADDR_I, OFF_IRQ_EN)) begin
      irq_en_q <= WDATA_I & IRQ_MASK;
    end
  end

  assign IRQ_O = |(irq_stat_q & irq_en_q);
  assign FLAGS3_O = flags3_q;

  // Read multiplexer; unmapped and write-only offsets read zero.
  always_comb begin
    case (ADDR_I)
      OFF_FLAGS3: rdata_d = flags3_q;
      OFF_EN1: rdata_d = en1_q;
      OFF_EN2: rdata_d = en2_q;
      OFF_EN3: rdata_d = en3_q;
      OFF_PRI1: rdata_d = pri1_q;
      OFF_CTRL: rdata_d = ctrl_q;
      OFF_IRQ_STAT: rdata_d = irq_stat_q;
      OFF_IRQ_EN: rdata_d = irq_en_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands for the single cycle after the read strobe.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else begin
      RDATA_O <= RD_I ? rdata_d : 8'h00;
    end
  end

  // Checks on the flag, enable and request behaviour.
  a_ssp_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    SSP2_DONE_I |=> flags3_q[BIT_SSP2])
    else $error("serial port two flag not set after done event");

  a_ssp_flag_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    flags3_q[BIT_SSP2] && !hit(WR_I, ADDR_I, OFF_FLAGS3) |=> flags3_q[BIT_SSP2])
    else $error("serial port two flag dropped without a software write");

  a_bcl_flag_clr: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit(WR_I, ADDR_I, OFF_FLAGS3) && !WDATA_I[BIT_BCL2] && !BCL2_DETECT_I
    |=> !flags3_q[BIT_BCL2])
    else $error("bus collision flag not cleared by a zero write");

  a_rx_flag_life: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX2_LOAD_I ##1 (!RX2_BUF_READ_I && !RX2_LOAD_I) [*2] |=> flags3_q[BIT_RX2])
    else $error("receiver flag lost before the buffer was read");

  a_tx_flag_clr: assert property (@(posedge CLK_I) disable iff (RST_I)
    TX2_BUF_WRITE_I && !TX2_EMPTIED_I |=> !flags3_q[BIT_TX2])
    else $error("transmitter flag not cleared by a buffer write");

  a_tmr_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    TMR4_MATCH_I |=> flags3_q[BIT_TMR4])
    else $error("timer four match flag not set");

  a_cap_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    CC_CAPTURE_I[0] && CC_MODE_I[1:0] == PIF_CC_CAPTURE |=> flags3_q[BIT_CC3])
    else $error("capture did not set the unit three flag");

  a_cmp_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    CC_MATCH_I[2] && CC_MODE_I[5:4] == PIF_CC_COMPARE |=> flags3_q[BIT_CC5])
    else $error("compare match did not set the unit five flag");

  a_pwm_no_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    CC_MODE_I[3:2] == PIF_CC_PWM && !flags3_q[BIT_CC3 + 1]
    && !hit(WR_I, ADDR_I, OFF_FLAGS3) |=> !flags3_q[BIT_CC3 + 1])
    else $error("unit four flag set while in pulse-width mode");

  a_global_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
    !prio_en && !global_en |=> !HI_REQ_O && !LO_REQ_O)
    else $error("peripheral request raised with global enable clear");

  a_en2_unimpl: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit(RD_I, ADDR_I, OFF_EN2) |=> (RDATA_O & ~EN2_MASK) == 8'h00)
    else $error("unimplemented enable bits read non-zero");

  a_prio_route: assert property (@(posedge CLK_I) disable iff (RST_I)
    prio_en && |(FLAGS1_I & en1_q & ~pri1_q) |=> LO_REQ_O)
    else $error("low priority source did not raise the low request");

  a_single_level: assert property (@(posedge CLK_I) disable iff (RST_I)
    !prio_en && global_en && |(flags3_q & en3_q) |=> HI_REQ_O && !LO_REQ_O)
    else $error("single-level mode did not route to the high request");

  a_bcl_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    BCL2_DETECT_I |=> flags3_q[BIT_BCL2])
    else $error("bus collision flag not set after a collision");

  a_rx_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    RX2_LOAD_I |=> flags3_q[BIT_RX2])
    else $error("receiver flag not set after a buffer load");

  a_tx_flag_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    TX2_EMPTIED_I |=> flags3_q[BIT_TX2])
    else $error("transmitter flag not set after the buffer emptied");

  // A software write must never move the two read-only flags.
  a_ro_bits_kept: assert property (@(posedge CLK_I) disable iff (RST_I)
    hit(WR_I, ADDR_I, OFF_FLAGS3) && !RX2_LOAD_I && !RX2_BUF_READ_I && !TX2_EMPTIED_I
    && !TX2_BUF_WRITE_I |=> flags3_q[BIT_RX2:BIT_TX2] == $past(flags3_q[BIT_RX2:BIT_TX2]))
    else $error("read-only receiver or transmitter flag changed by a software write");

  a_hi_route: assert property (@(posedge CLK_I) disable iff (RST_I)
    prio_en && |(FLAGS1_I & en1_q & pri1_q) |=> HI_REQ_O)
    else $error("high priority source did not raise the high request");

  // With no source both flagged and enabled, neither request line may rise.
  a_enable_block: assert property (@(posedge CLK_I) disable iff (RST_I)
    !(|(FLAGS1_I & en1_q)) && !(|(FLAGS2_I & en2_q)) && !(|(flags3_q & en3_q))
    |=> !HI_REQ_O && !LO_REQ_O)
    else $error("request raised with every pending source blocked by its enable");

  a_stat_hi_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    hi_rise |=> irq_stat_q[BIT_EV_HI])
    else $error("high request rise not recorded in the status register");

  a_stat_lo_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    lo_rise |=> irq_stat_q[BIT_EV_LO])
    else $error("low request rise not recorded in the status register");

endmodule : pif_bank_top

// ---- tb/pif_periph_model.sv ----
// Behavioural peripheral event sources that feed the interrupt bank.
// Assumes one core clock; the bench calls fire between clock edges.
`timescale 1ns/100ps
module pif_periph_model (
  input wire logic clk_i,
  output logic [12:0] ev_o
);
  // Sources start idle so that no flag is set before the bench asks.
  initial ev_o = 13'h0;

  // Raises the chosen events for exactly one cycle, as a peripheral would.
  task automatic fire(input logic [12:0] m);
    @(posedge clk_i);
    ev_o <= m;
    @(posedge clk_i);
    ev_o <= 13'h0;
  endtask : fire
endmodule : pif_periph_model

// ---- tb/peripheral_irq_flag_enable_priority_bench.sv ----
// Self-checking bench for the peripheral interrupt flag, enable and priority bank.
// Assumes the event model drives the peripheral inputs and a 40 MHz core clock.
`timescale 1ns/100ps
module peripheral_irq_flag_enable_priority_bench;
  import pif_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [5:0] CC_MODE_I = 6'h00;
  logic [7:0] FLAGS1_I = 8'h00, FLAGS2_I = 8'h00, PRIO2_I = 8'h00, PRIO3_I = 8'h00;
  logic [7:0] RDATA_O, FLAGS3_O;
  logic HI_REQ_O, LO_REQ_O, IRQ_O;
  wire logic [12:0] ev;
  logic [7:0] sh [0:15] = '{default: 8'h00};
  int err_total = 0;
  int n_checks = 0;
  int seed = 22;
  int ev_idx [0:4] = '{0, 1, 2, 4, 6};
  int fl_bit [0:4] = '{7, 6, 5, 4, 3};

  // Core clock at 25 ns.
  always #12.5 CLK_I = ~CLK_I;

  pif_periph_model u_src (.clk_i(CLK_I), .ev_o(ev));

  pif_bank_top u_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .SSP2_DONE_I(ev[0]), .BCL2_DETECT_I(ev[1]),
    .RX2_LOAD_I(ev[2]), .RX2_BUF_READ_I(ev[3]), .TX2_EMPTIED_I(ev[4]),
    .TX2_BUF_WRITE_I(ev[5]), .TMR4_MATCH_I(ev[6]), .CC_CAPTURE_I(ev[9:7]),
    .CC_MATCH_I(ev[12:10]), .CC_MODE_I(CC_MODE_I), .FLAGS1_I(FLAGS1_I),
    .FLAGS2_I(FLAGS2_I), .PRIO2_I(PRIO2_I), .PRIO3_I(PRIO3_I), .FLAGS3_O(FLAGS3_O),
    .HI_REQ_O(HI_REQ_O), .LO_REQ_O(LO_REQ_O), .IRQ_O(IRQ_O)
  );

  // Bits that read back after a software write to each offset.
  function automatic logic [7:0] rmask(input logic [3:0] a);
    case (a)
      OFF_FLAGS3: return 8'hcf;
      OFF_EN1, OFF_EN3, OFF_PRI1: return 8'hff;
      OFF_EN2: return 8'hcb;
      OFF_CTRL: return 8'hc0;
      OFF_IRQ_EN: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : rmask

  // Expected high and low requests from the shadow registers and bank inputs.
  function automatic logic [1:0] exp_req();
    logic [23:0] p;
    logic [23:0] pr;
    p = {FLAGS1_I & sh[OFF_EN1], FLAGS2_I & sh[OFF_EN2], sh[OFF_FLAGS3] & sh[OFF_EN3]};
    pr = {sh[OFF_PRI1], PRIO2_I, PRIO3_I};
    if (sh[OFF_CTRL][7]) begin
      return {|(p & pr), |(p & ~pr)};
    end
    return {sh[OFF_CTRL][6] & (|p), 1'b0};
  endfunction : exp_req

  // Compares one value and counts the outcome.
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // One-cycle register write; the shadow keeps what should read back.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    sh[a] = d & rmask(a);
  endtask : wr

  // One-cycle register read; data is checked in the following cycle only.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    #1;
    chk(RDATA_O, e);
  endtask : rd

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (err_total == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // Cuts a hang short well after the expected run length.
  initial begin
    #750000;
    err_total++;
    final_report();
  end

  // Main sequence.
  initial begin
    logic [1:0] r;
    logic [3:0] a4;
    sh[OFF_PRI1] = 8'hff;
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    for (int a = 0; a < 16; a++) rd(4'(a), sh[a]);
    // Priority levels on and every first-bank flag high, but all enables clear.
    @(posedge CLK_I);
    FLAGS1_I <= 8'hff;
    wr(OFF_CTRL, 8'hc0);
    for (int k = 0; k < 5; k++) begin
      u_src.fire(13'h1 << ev_idx[k]);
      #1;
      chk(FLAGS3_O, 8'h1 << fl_bit[k]);
      wr(OFF_FLAGS3, 8'h00);
      #1;
      chk(FLAGS3_O, (fl_bit[k] inside {4, 5}) ? 8'h1 << fl_bit[k] : 8'h00);
      chk({HI_REQ_O, LO_REQ_O}, 2'b00);
      u_src.fire(13'h28);
      #1;
      chk(FLAGS3_O, 8'h00);
    end
    u_src.fire(13'h0c);
    #1;
    chk(FLAGS3_O, 8'h20);
    u_src.fire(13'h08);
    for (int u = 0; u < 3; u++) begin
      for (int m = 0; m < 4; m++) begin
        @(posedge CLK_I);
        CC_MODE_I <= 6'(m) << (2 * u);
        u_src.fire(13'h80 << u);
        #1;
        chk(FLAGS3_O, (m == 1) ? 8'h1 << u : 8'h00);
        wr(OFF_FLAGS3, 8'h00);
        u_src.fire(13'h400 << u);
        #1;
        chk(FLAGS3_O, (m == 2) ? 8'h1 << u : 8'h00);
        wr(OFF_FLAGS3, 8'h00);
      end
    end
    for (int i = 0; i < 27; i++) begin
      a4 = (i % 9 == 6) ? 4'hf : 4'(i % 9);
      wr(a4, 8'($random(seed)));
      rd(a4, sh[a4]);
    end
    repeat (40) begin
      @(posedge CLK_I);
      FLAGS1_I <= 8'($random(seed));
      FLAGS2_I <= 8'($random(seed));
      PRIO2_I <= 8'($random(seed));
      PRIO3_I <= 8'($random(seed));
      for (int a = 0; a < 5; a++) wr(4'(a), 8'($random(seed)));
      wr(OFF_CTRL, 8'($random(seed)));
      repeat (2) @(posedge CLK_I);
      #1;
      r = exp_req();
      chk({HI_REQ_O, LO_REQ_O}, r);
    end
    @(posedge CLK_I);
    FLAGS1_I <= 8'h01;
    FLAGS2_I <= 8'h00;
    wr(OFF_CTRL, 8'h00);
    wr(OFF_FLAGS3, 8'h00);
    wr(OFF_EN1, 8'h01);
    wr(OFF_IRQ_CLR, 8'hff);
    wr(OFF_IRQ_EN, 8'h03);
    rd(OFF_IRQ_STAT, 8'h00);
    wr(OFF_CTRL, 8'h40);
    repeat (2) @(posedge CLK_I);
    #1;
    chk(IRQ_O, 1'b1);
    rd(OFF_IRQ_STAT, 8'h01);
    wr(OFF_IRQ_EN, 8'h02);
    #1;
    chk(IRQ_O, 1'b0);
    wr(OFF_IRQ_CLR, 8'h01);
    rd(OFF_IRQ_STAT, 8'h00);
    wr(OFF_PRI1, 8'h00);
    wr(OFF_CTRL, 8'hc0);
    repeat (2) @(posedge CLK_I);
    #1;
    chk({HI_REQ_O, LO_REQ_O}, 2'b01);
    chk(IRQ_O, 1'b1);
    rd(OFF_IRQ_STAT, 8'h02);
    final_report();
  end
endmodule : peripheral_irq_flag_enable_priority_bench
